// File: dma_channel_linked_list_control_tb_top.sv
`timescale 1ns/1ps
`include "dmc_defs.svh"
module dma_channel_linked_list_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic m_req, m_we, m_ack, m_err, irq, rd_err;
  logic req_d = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, m_addr, m_wdata, m_rdata, rd, v;
  logic [15:0] periph_req;
  logic [1:0] m_size;
  integer num_errors = 0, samples_checked = 0, seed = 32'h72d1;
  integer cycles = 0, reqs = 0, i, r0;
  logic [31:0] ccfg [0:2] = '{32'h8001, 32'h0001, 32'h8001};
  logic [31:0] cmsk [0:2] = '{32'h1, 32'h1, 32'h0};
  logic [31:0] cst [0:2] = '{32'h1, 32'h0, 32'h1};
  logic [31:0] ectl [0:3] = '{32'h3001, 32'h2001, 32'h1001, 32'h2001};
  logic [31:0] esrc [0:3] = '{32'h200, 32'h202, 32'h201, 32'h200};
  logic [31:0] ecfg [0:3] = '{32'h4801, 32'h4801, 32'h4801, 32'h6801};
  dmc_channel DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .m_req(m_req), .m_we(m_we),
    .m_addr(m_addr), .m_wdata(m_wdata), .m_size(m_size), .m_ack(m_ack),
    .m_err(m_err), .m_rdata(m_rdata), .irq(irq));
  dmc_mem_model u_mem (.pclk(pclk), .presetn(presetn), .m_req(m_req),
    .m_we(m_we), .m_addr(m_addr), .m_wdata(m_wdata), .m_size(m_size),
    .m_ack(m_ack), .m_err(m_err), .m_rdata(m_rdata));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    req_d <= m_req;
    if (m_req && !req_d) reqs++;
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================
  // apb master
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    check(rd, e);
  endtask
  task automatic prog(input logic [31:0] s, d, n, c);
    apb(`DMC_OFS_SRC, 1'b1, s);
    apb(`DMC_OFS_DST, 1'b1, d);
    apb(`DMC_OFS_NEXT, 1'b1, n);
    apb(`DMC_OFS_CTL, 1'b1, c);
  endtask
  task automatic wait_idle;
    integer n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 300) begin
      apb(`DMC_OFS_ENCH, 1'b0, 32'h0);
      n++;
    end
    if (n == 300) num_errors++;
  endtask
  // ==========================================
  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, periph_req} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 9; i++) rchk(8'(i * 4), `DMC_RST_WORD);
    apb(8'h40, 1'b0, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    for (i = 0; i < 4; i++) begin
      v = $random(seed) & ~32'h1;
      apb(`DMC_OFS_CFG, 1'b1, v);
      rchk(`DMC_OFS_CFG, v & `DMC_CFG_WMASK & ~32'h2_0000);
    end
    for (r0 = 0; r0 < 3; r0++) begin
      for (i = 0; i < 5; i++) begin
        u_mem.words[128 + i] = $random(seed);
        u_mem.words[192 + i] = 32'h0;
      end
      u_mem.words[32] = 32'h208;
      u_mem.words[33] = 32'h308;
      u_mem.words[34] = `DMC_LLI_NULL;
      u_mem.words[35] = 32'h8000_e003;
      apb(`DMC_OFS_MASK, 1'b1, cmsk[r0]);
      prog(32'h200, 32'h300, 32'h80, 32'he002);
      apb(`DMC_OFS_CFG, 1'b1, ccfg[r0]);
      wait_idle;
      for (i = 0; i < 5; i++) begin
        check(u_mem.words[192 + i], u_mem.words[128 + i]);
      end
      rchk(`DMC_OFS_SRC, 32'h214);
      rchk(`DMC_OFS_NEXT, 32'h0);
      rchk(`DMC_OFS_CTL, 32'h8000_e000);
      rchk(`DMC_OFS_CFG, ccfg[r0] & ~32'h1);
      rchk(`DMC_OFS_STAT, cst[r0]);
      check({31'h0, irq}, cst[r0] & cmsk[r0]);
      apb(`DMC_OFS_TCCLR, 1'b1, 32'h1);
      rchk(`DMC_OFS_STAT, 32'h0);
      check({31'h0, irq}, 32'h0);
    end
    apb(`DMC_OFS_MASK, 1'b1, 32'h2);
    for (i = 0; i < 4; i++) begin
      prog(esrc[i], 32'h300, 32'h0, ectl[i]);
      apb(`DMC_OFS_CFG, 1'b1, ecfg[i]);
      repeat (4) @(posedge pclk);
      rchk(`DMC_OFS_STAT, 32'h2);
      check({31'h0, irq}, 32'h1);
      rchk(`DMC_OFS_CFG, ecfg[i] & ~32'h1);
      apb(`DMC_OFS_STAT, 1'b1, 32'h2);
    end
    prog(32'h200, 32'h340, 32'h0, 32'ha001);
    apb(`DMC_OFS_CFG, 1'b1, 32'h4_1007);
    periph_req <= 16'h0008;
    r0 = reqs;
    repeat (20) @(posedge pclk);
    check(reqs, r0);
    apb(`DMC_OFS_CFG, 1'b1, 32'h4_1006);
    apb(`DMC_OFS_CFG, 1'b1, 32'h1007);
    wait_idle;
    check(reqs, r0 + 2);
    check(u_mem.words[208], u_mem.words[128]);
    prog(32'h400, 32'h800, 32'h0, 32'he064);
    apb(`DMC_OFS_CFG, 1'b1, 32'h1007);
    repeat (30) @(posedge pclk);
    apb(`DMC_OFS_CFG, 1'b1, 32'h4_1007);
    i = 0;
    do begin
      apb(`DMC_OFS_CFG, 1'b0, 32'h0);
      i++;
    end while (rd[17] !== 1'b0 && i < 20);
    check({31'h0, rd[17]}, 32'h0);
    rchk(`DMC_OFS_ENCH, 32'h1);
    apb(`DMC_OFS_CFG, 1'b1, 32'h4_1006);
    rchk(`DMC_OFS_CFG, 32'h4_1006);
    periph_req <= 16'h0;
    apb(`DMC_OFS_CFG, 1'b1, 32'h1);
    repeat (30) @(posedge pclk);
    apb(`DMC_OFS_CFG, 1'b1, 32'h0);
    rchk(`DMC_OFS_CFG, 32'h0);
    repeat (10) @(posedge pclk);
    r0 = reqs;
    repeat (20) @(posedge pclk);
    check(reqs, r0);
    rchk(`DMC_OFS_ENCH, 32'h0);
    report_and_stop;
  end
endmodule
bind dmc_channel dmc_channel_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_req(periph_req), .m_req(m_req), .m_we(m_we), .m_addr(m_addr),
  .m_wdata(m_wdata), .m_size(m_size), .m_ack(m_ack), .m_err(m_err),
  .m_rdata(m_rdata), .irq(irq));

// File: dmc_channel.sv
// Contract
// - config bit 0 written 1 runs the channel, written 0 stops it
// - disabling mid-transfer drops held data; software reinitialises after
// - memory-to-memory starts on enable write, no request needed
// - width and address mismatch stops the channel and sets error status if bit 14 is set
// - at block end reload addresses, count, width from next item
// - item is four words: source, destination, next pointer, control
// - item end raises terminal count if its control word enables it and config bit 15 is set
// - writing terminal count clear bit clears the pending interrupt
// - null next pointer finishes block and stops the channel
// - halt bit 18 set ignores source peripheral requests, clear accepts
// - read-only bit 17 shows held data in the channel buffer
// - flow field 13-11: 000 m2m, 001 m2p, 010 p2m, 011 p2p
// - bit 15 set permits the transfer-end interrupt, clear blocks it
`timescale 1ns/1ps
`include "dmc_defs.svh"
module dmc_channel
  import dmc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral requests from pins
  input wire logic [15:0] periph_req,
  // memory master port
  output logic m_req,
  output logic m_we,
  output logic [31:0] m_addr,
  output logic [31:0] m_wdata,
  output logic [1:0] m_size,
  input wire logic m_ack,
  input wire logic m_err,
  input wire logic [31:0] m_rdata,
  // interrupt
  output logic irq
);
  dmc_top_t r, n;
  logic [15:0] req_s;
  dmc_mem_if mi ();

  // ==========================================
  // submodules
  dmc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(periph_req),
    .dout(req_s)
  );

  dmc_xfer u_xfer (
    .pclk(pclk),
    .presetn(presetn),
    .mi(mi),
    .m_req(m_req),
    .m_we(m_we),
    .m_addr(m_addr),
    .m_wdata(m_wdata),
    .m_size(m_size),
    .m_ack(m_ack),
    .m_err(m_err),
    .m_rdata(m_rdata)
  );

  assign mi.start = r.start;
  assign mi.we = r.we;
  assign mi.addr = r.addr;
  assign mi.wdata = r.wdata;
  assign mi.size = r.size;

  // ==========================================
  // decoded fields
  dmc_flow_t flow;
  logic [1:0] size;
  logic [11:0] cnt;
  logic src_per, dst_per, src_ok, dst_ok, bad_cfg;
  logic [31:0] step;

  function automatic logic misal(input logic [31:0] a,
                                 input logic [1:0] s);
    misal = (s == 2'h1 && a[0]) || (s == `DMC_SIZE_WORD && |a[1:0]);
  endfunction

  always_comb begin
    flow = dmc_flow_t'(r.cfg[`DMC_CFG_FLOW +: 3]);
    size = r.ctl[`DMC_CTL_SIZE +: 2];
    cnt = r.ctl[`DMC_CTL_CNT +: 12];
    step = 32'h0000_0001 << size;
    src_per = (flow == FLOW_P2M) || (flow == FLOW_P2P);
    dst_per = (flow == FLOW_M2P) || (flow == FLOW_P2P);
    src_ok = !src_per || (req_s[r.cfg[`DMC_CFG_SRCP +: 4]] &&
      !r.cfg[`DMC_CFG_HALT]);
    dst_ok = !dst_per || req_s[r.cfg[`DMC_CFG_DSTP +: 4]];
    bad_cfg = size == `DMC_SIZE_BAD || misal(r.src, size) ||
      misal(r.dst, size) || r.cfg[`DMC_CFG_FLOW + 2];
  end

  // ==========================================
  // main state update
  logic blk_end, ev_tc, ev_err, wr, setup;
  logic [1:0] w1c;
  logic [31:0] rd;
  logic hit;

  always_comb begin
    n = r;
    n.start = 1'b0;
    blk_end = 1'b0;
    ev_tc = 1'b0;
    ev_err = 1'b0;
    w1c = 2'b00;
    rd = `DMC_RST_WORD;
    hit = 1'b1;
    setup = psel && !penable;
    wr = psel && penable && r.pready && pwrite;

    // channel sequencer
    case (r.state)
      ST_WAIT: begin
        if (bad_cfg) begin
          ev_err = 1'b1;
        end else if (cnt == 12'h000) begin
          blk_end = 1'b1;
        end else if (src_ok) begin
          n.state = ST_READ;
        end
      end
      ST_READ: begin
        if (!r.issued && !mi.busy) begin
          n.start = 1'b1;
          n.we = 1'b0;
          n.addr = r.src;
          n.size = size;
          n.issued = 1'b1;
        end else if (r.issued && mi.done) begin
          n.issued = 1'b0;
          if (mi.err) begin
            ev_err = 1'b1;
          end else begin
            n.hold = mi.rdata;
            n.hold_vld = 1'b1;
            n.state = ST_WRITE;
          end
        end
      end
      ST_WRITE: begin
        if (!r.issued && !mi.busy && dst_ok) begin
          n.start = 1'b1;
          n.we = 1'b1;
          n.addr = r.dst;
          n.wdata = r.hold;
          n.size = size;
          n.issued = 1'b1;
        end else if (r.issued && mi.done) begin
          n.issued = 1'b0;
          if (mi.err) begin
            ev_err = 1'b1;
          end else begin
            n.hold_vld = 1'b0;
            if (r.ctl[`DMC_CTL_SINC]) begin
              n.src = r.src + step;
            end
            if (r.ctl[`DMC_CTL_DINC]) begin
              n.dst = r.dst + step;
            end
            n.ctl[`DMC_CTL_CNT +: 12] = cnt - 12'h001;
            n.state = ST_WAIT;
            blk_end = (cnt == 12'h001);
          end
        end
      end
      ST_FETCH: begin
        if (!r.issued && !mi.busy) begin
          n.start = 1'b1;
          n.we = 1'b0;
          n.addr = r.fbase + {28'h000_0000, r.fidx, 2'b00};
          n.size = `DMC_SIZE_WORD;
          n.issued = 1'b1;
        end else if (r.issued && mi.done) begin
          n.issued = 1'b0;
          if (mi.err) begin
            ev_err = 1'b1;
          end else begin
            case (r.fidx)
              2'h0: n.src = mi.rdata;
              2'h1: n.dst = mi.rdata;
              2'h2: n.nxt = mi.rdata;
              default: n.ctl = mi.rdata;
            endcase
            n.fidx = r.fidx + 2'h1;
            if (r.fidx == 2'h3) begin
              n.state = ST_WAIT;
            end
          end
        end
      end
      default: ;
    endcase

    if (blk_end) begin
      ev_tc = r.ctl[`DMC_CTL_TCIE] && r.cfg[`DMC_CFG_TCMASK];
      if (r.nxt == `DMC_LLI_NULL) begin
        n.cfg[`DMC_CFG_EN] = 1'b0;
        n.state = ST_IDLE;
      end else begin
        n.fbase = r.nxt;
        n.fidx = 2'h0;
        n.state = ST_FETCH;
      end
    end
    if (ev_err) begin
      n.cfg[`DMC_CFG_EN] = 1'b0;
      n.hold_vld = 1'b0;
      n.state = ST_IDLE;
    end

    // register read decode
    if (paddr == `DMC_OFS_SRC) begin
      rd = r.src;
    end else if (paddr == `DMC_OFS_DST) begin
      rd = r.dst;
    end else if (paddr == `DMC_OFS_NEXT) begin
      rd = r.nxt;
    end else if (paddr == `DMC_OFS_CTL) begin
      rd = r.ctl;
    end else if (paddr == `DMC_OFS_CFG) begin
      rd = r.cfg;
      rd[`DMC_CFG_ACTIVE] = r.hold_vld;
    end else if (paddr == `DMC_OFS_STAT) begin
      rd = {30'h0, r.stat};
    end else if (paddr == `DMC_OFS_MASK) begin
      rd = {30'h0, r.mask};
    end else if (paddr == `DMC_OFS_TCCLR) begin
      rd = `DMC_RST_WORD;
    end else if (paddr == `DMC_OFS_ENCH) begin
      rd = {31'h0, r.cfg[`DMC_CFG_EN]};
    end else begin
      hit = 1'b0;
    end

    // apb answer is one cycle after setup
    n.pready = setup;
    n.pslverr = setup && !hit;
    n.prdata = (setup && !pwrite) ? rd : `DMC_RST_WORD;

    // software writes other than status clears take precedence over the sequencer
    if (wr && hit) begin
      if (paddr == `DMC_OFS_SRC) begin
        n.src = pwdata;
      end else if (paddr == `DMC_OFS_DST) begin
        n.dst = pwdata;
      end else if (paddr == `DMC_OFS_NEXT) begin
        n.nxt = pwdata;
      end else if (paddr == `DMC_OFS_CTL) begin
        n.ctl = pwdata;
      end else if (paddr == `DMC_OFS_CFG) begin
        n.cfg = pwdata & `DMC_CFG_WMASK;
        if (!pwdata[`DMC_CFG_EN]) begin
          n.state = ST_IDLE;
          n.hold_vld = 1'b0;
          n.issued = 1'b0;
          n.start = 1'b0;
        end else if (!r.cfg[`DMC_CFG_EN]) begin
          n.state = ST_WAIT;
        end
      end else if (paddr == `DMC_OFS_STAT) begin
        w1c = pwdata[1:0];
      end else if (paddr == `DMC_OFS_MASK) begin
        n.mask = pwdata[1:0];
      end else if (paddr == `DMC_OFS_TCCLR) begin
        w1c[`DMC_INT_TC] = pwdata[`DMC_INT_TC];
      end
    end

    // sticky status, a new event beats a clear
    n.stat = r.stat & ~w1c;
    n.stat[`DMC_INT_TC] = n.stat[`DMC_INT_TC] | ev_tc;
    n.stat[`DMC_INT_ERR] = n.stat[`DMC_INT_ERR] |
      (ev_err && r.cfg[`DMC_CFG_ERRIE]);
    n.irq = |(n.stat & n.mask);
  end

  // ==========================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
endmodule

// File: dmc_channel_asserts.sv
`timescale 1ns/1ps
`include "dmc_defs.svh"
module dmc_channel_asserts (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // requests, memory, interrupt
  input wire logic [15:0] periph_req,
  input wire logic m_req,
  input wire logic m_we,
  input wire logic [31:0] m_addr,
  input wire logic [31:0] m_wdata,
  input wire logic [1:0] m_size,
  input wire logic m_ack,
  input wire logic m_err,
  input wire logic [31:0] m_rdata,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================
  // sequences
  sequence s_cfg_wr;
    psel && penable && pready && pwrite && paddr == `DMC_OFS_CFG;
  endsequence
  sequence s_quiet;
    !m_req [*4];
  endsequence
  // ==========================================
  // properties
  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("late ready");
  property p_idle;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("idle bus value");
  property p_bad;
    psel && !penable && paddr > 8'h20 && paddr[1:0] == 2'h0 |=> pslverr;
  endproperty
  a_bad: assert property (p_bad) else $error("no slave error");
  property p_hold;
    m_req && !m_ack |=> m_req && $stable(m_addr) && $stable(m_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_drop;
    m_req && m_ack |=> !m_req;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept");
  property p_width;
    m_req |-> m_size != `DMC_SIZE_BAD;
  endproperty
  a_width: assert property (p_width) else $error("bad width");
  property p_align;
    m_req |-> (m_size != 2'h2 || m_addr[1:0] == 2'h0) &&
      (m_size != 2'h1 || !m_addr[0]);
  endproperty
  a_align: assert property (p_align) else $error("misaligned");
  property p_start;
    s_cfg_wr ##0 (pwdata[0] && pwdata[13:11] == 3'h0) |-> ##[1:8] m_req;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop;
    s_cfg_wr ##0 !pwdata[0] |-> ##[1:8] s_quiet;
  endproperty
  a_stop: assert property (p_stop) else $error("not stopped");
endmodule

// File: dmc_defs.svh
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
// ==========================================
// register byte offsets
`define DMC_OFS_SRC 8'h00
`define DMC_OFS_DST 8'h04
`define DMC_OFS_NEXT 8'h08
`define DMC_OFS_CTL 8'h0c
`define DMC_OFS_CFG 8'h10
`define DMC_OFS_STAT 8'h14
`define DMC_OFS_MASK 8'h18
`define DMC_OFS_TCCLR 8'h1c
`define DMC_OFS_ENCH 8'h20
// ==========================================
// channel config fields
`define DMC_CFG_EN 0
`define DMC_CFG_SRCP 1
`define DMC_CFG_DSTP 6
`define DMC_CFG_FLOW 11
`define DMC_CFG_ERRIE 14
`define DMC_CFG_TCMASK 15
`define DMC_CFG_LOCK 16
`define DMC_CFG_ACTIVE 17
`define DMC_CFG_HALT 18
`define DMC_CFG_WMASK 32'h0007_fbdf
// ==========================================
// channel control word fields
`define DMC_CTL_CNT 0
`define DMC_CTL_SIZE 12
`define DMC_CTL_SINC 14
`define DMC_CTL_DINC 15
`define DMC_CTL_TCIE 31
// ==========================================
// interrupt status bits, reset value, null next pointer and width codes
`define DMC_INT_TC 0
`define DMC_INT_ERR 1
`define DMC_RST_WORD 32'h0000_0000
`define DMC_LLI_NULL 32'h0000_0000
`define DMC_SIZE_WORD 2'h2
`define DMC_SIZE_BAD 2'h3
`endif

// File: dmc_mem_if.sv
`timescale 1ns/1ps
interface dmc_mem_if;
  logic start;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [1:0] size;
  logic busy;
  logic done;
  logic err;
  logic [31:0] rdata;
  modport ctl (output start, we, addr, wdata, size,
    input busy, done, err, rdata);
  modport eng (input start, we, addr, wdata, size,
    output busy, done, err, rdata);
endinterface

// File: dmc_mem_model.sv
`timescale 1ns/1ps
module dmc_mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // memory slave side
  input wire logic m_req,
  input wire logic m_we,
  input wire logic [31:0] m_addr,
  input wire logic [31:0] m_wdata,
  input wire logic [1:0] m_size,
  output logic m_ack,
  output logic m_err,
  output logic [31:0] m_rdata
);
  logic [31:0] words [0:1023];
  logic [1:0] wait_cnt;
  logic [1:0] lat;
  assign m_err = 1'b0;
  // latency rotates 0..3; data toggles when not answering
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ack <= 1'b0;
      wait_cnt <= 2'h0;
      lat <= 2'h0;
      m_rdata <= 32'h0;
    end else if (m_ack) begin
      m_ack <= 1'b0;
      wait_cnt <= lat;
      lat <= lat + 2'h1;
      m_rdata <= ~m_rdata;
    end else if (m_req && wait_cnt == 2'h0) begin
      m_ack <= 1'b1;
      m_rdata <= m_we ? ~m_rdata : words[m_addr[11:2]];
      if (m_we) begin
        words[m_addr[11:2]] <= m_wdata;
      end
    end else begin
      wait_cnt <= m_req ? wait_cnt - 2'h1 : wait_cnt;
      m_rdata <= ~m_rdata;
    end
  end
endmodule

// File: dmc_pkg.sv
package dmc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_FETCH = 3'b100
  } dmc_state_t;

  typedef enum logic [2:0] {
    FLOW_M2M = 3'b000,
    FLOW_M2P = 3'b001,
    FLOW_P2M = 3'b010,
    FLOW_P2P = 3'b011
  } dmc_flow_t;

  typedef struct packed {
    dmc_state_t state;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] nxt;
    logic [31:0] ctl;
    logic [31:0] cfg;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] hold;
    logic hold_vld;
    logic [31:0] fbase;
    logic [1:0] fidx;
    logic issued;
    logic start;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } dmc_top_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic err;
    logic [31:0] rdata;
    logic m_req;
    logic m_we;
    logic [31:0] m_addr;
    logic [31:0] m_wdata;
    logic [1:0] m_size;
  } dmc_xfer_t;

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] q;
  } dmc_sync_t;
endpackage

// File: dmc_sync.sv
`timescale 1ns/1ps
module dmc_sync
  import dmc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw and filtered requests
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  dmc_sync_t r, n;

  always_comb begin
    n = r;
    n.s1 = din;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // a change counts once stages two and three agree
    n.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dout = r.q;
endmodule

// File: dmc_xfer.sv
`timescale 1ns/1ps
module dmc_xfer
  import dmc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request side
  dmc_mem_if.eng mi,
  // memory master port
  output logic m_req,
  output logic m_we,
  output logic [31:0] m_addr,
  output logic [31:0] m_wdata,
  output logic [1:0] m_size,
  input wire logic m_ack,
  input wire logic m_err,
  input wire logic [31:0] m_rdata
);
  dmc_xfer_t r, n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    if (!r.busy && mi.start) begin
      n.busy = 1'b1;
      n.m_req = 1'b1;
      n.m_we = mi.we;
      n.m_addr = mi.addr;
      n.m_wdata = mi.wdata;
      n.m_size = mi.size;
    end else if (r.m_req && m_ack) begin
      n.busy = 1'b0;
      n.m_req = 1'b0;
      n.done = 1'b1;
      n.err = m_err;
      n.rdata = m_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign mi.busy = r.busy;
  assign mi.done = r.done;
  assign mi.err = r.err;
  assign mi.rdata = r.rdata;
  assign m_req = r.m_req;
  assign m_we = r.m_we;
  assign m_addr = r.m_addr;
  assign m_wdata = r.m_wdata;
  assign m_size = r.m_size;
endmodule
